// ### design/two_wire_defines.vh
/*
 * Shared constants for the two-wire register slave: widths, state and
 * phase codes, bit counts and reset values.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH

// widths
`define TW_ADDR_W 8
`define TW_DATA_W 16
`define TW_BYTE_W 8
`define TW_CNT_W 4
`define TW_ST_W 3
`define TW_PH_W 2

// bit counter values
`define TW_CNT_ZERO 4'h0
`define TW_CNT_STEP 4'h1
`define TW_CNT_FULL 4'h8

// slave states
`define TW_ST_IDLE 3'h0
`define TW_ST_RECV 3'h1
`define TW_ST_RACK 3'h2
`define TW_ST_SEND 3'h3
`define TW_ST_SACK 3'h4

// meaning of the next received byte
`define TW_PH_ID 2'h0
`define TW_PH_ADDR 2'h1
`define TW_PH_HI 2'h2
`define TW_PH_LO 2'h3

// direction bit and line levels
`define TW_DIR_READ 1'b1
`define TW_LINE_LOW 1'b0
`define TW_RELEASE 1'b1
`define TW_DRIVE 1'b0

// reset values
`define TW_REG_RESET 16'h0000
`define TW_ADDR_RESET 8'h00
`define TW_BYTE_RESET 8'h00

`endif

// ### design/pin_sync.v
/*
 * Two-stage synchroniser for pin inputs.
 * Assumes asynchronous inputs; only sync_q may be read by other logic.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 2
) (
	// clock and reset
	input wire system_clock,
	input wire rst_b,
	// pins in, synchronised out
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_q
);

	reg [WIDTH-1:0] stage_q;

	// idle bus level is high, so both stages reset high
	always @(posedge system_clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage_q <= {WIDTH{1'b1}};
			sync_q <= {WIDTH{1'b1}};
		end
		else
		begin
			stage_q <= async_in;
			sync_q <= stage_q;
		end
	end

endmodule // pin_sync

`default_nettype wire

// ### design/reg_store.v
/*
 * Register map storage: one write port, one registered read port.
 * Assumes a single writer on system_clock; every entry resets to a known value.
 */
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defines.vh"

module reg_store #(
	parameter AW = `TW_ADDR_W,
	parameter DW = `TW_DATA_W
) (
	// clock and reset
	input wire system_clock,
	input wire rst_b,
	// write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// read port
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data_q
);

	localparam DEPTH = 1 << AW;

	reg [DW-1:0] mem_q [0:DEPTH-1];

	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1)
		begin : g_entry
			localparam [AW-1:0] ENTRY = i;
			always @(posedge system_clock or negedge rst_b)
			begin
				if (!rst_b)
					mem_q[i] <= `TW_REG_RESET;
				else if (wr_en && (wr_addr == ENTRY))
					mem_q[i] <= wr_data;
			end
		end
	endgenerate

	always @(posedge system_clock or negedge rst_b)
	begin
		if (!rst_b)
			rd_data_q <= `TW_REG_RESET;
		else
			rd_data_q <= mem_q[rd_addr];
	end

endmodule // reg_store

`default_nettype wire

// ### design/two_wire_register_slave.v
/*
 * Two-wire serial slave giving a bus master read and write access to an
 * 8-bit addressed map of 16-bit registers, with auto-increment.
 * Assumes the master drives scl; sda is open drain with an external pull-up.
 * The link is oversampled by system_clock; scl must stay high and low for at
 * least four system_clock periods each.
 */
// Notes on behaviour
// - slave only: scl is an input, sda is bidirectional
// - a one on sda is sent by releasing the line, never driving high
// - fixed 8-bit identifier, bit 0 is direction, one means read
// - sda falling while scl high is a start; receive identifier next
// - after start, shift in eight bits msb first as identifier
// - matching identifier is acknowledged by holding sda low one clock
// - mismatch, or read while write-only, goes idle without acknowledge
// - sda rising while scl high is a stop
// - after a complete sequence, return to idle awaiting start
// - sda changing while scl high mid-transfer abandons it; a rise goes idle, a fall awaits a new identifier
// - register address is its own 8-bit byte, apart from identifier
// - single and multiple reads and writes with auto-increment
// - every register can be read back
// - auto-increment steps through consecutive register addresses
// - address pointer kept, one past the last word accessed; read without address phase starts there
// - in acknowledge slot low means acknowledge, high means not
// - registers are sixteen bits, bit 15 most significant
// - no register reads or writes while the sequencer is busy, except the first byte after a read identifier
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defines.vh"

module two_wire_register_slave #(
	parameter [6:0] DEV_ID = 7'h2B, // arbitrary value
	parameter AW = `TW_ADDR_W,
	parameter DW = `TW_DATA_W
) (
	// system clock and reset
	input wire system_clock,
	input wire rst_b,
	// two-wire pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_q,
	output reg sda_oe_b_q,
	// device controls
	input wire sequencer_busy_flag,
	input wire write_only,
	// register write notification to the rest of the device
	output reg wr_strobe_q,
	output reg [AW-1:0] wr_addr_q,
	output reg [DW-1:0] wr_data_q,
	// transfer status
	output reg selected_q
);

	////////////////////////////////////////////////////////////////////////
	// pin sampling and bus conditions

	wire scl_s;
	wire sda_s;
	reg scl_p_q;
	reg sda_p_q;

	pin_sync #(
		.WIDTH(2)
	) u_sync (
		.system_clock(system_clock),
		.rst_b(rst_b),
		.async_in({scl_in, sda_in}),
		.sync_q({scl_s, sda_s})
	);

	always @(posedge system_clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	wire scl_rise = scl_s && !scl_p_q;
	wire scl_fall = !scl_s && scl_p_q;
	// sda edges while scl stays high are conditions, wherever they occur
	wire start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
	wire stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

	////////////////////////////////////////////////////////////////////////
	// protocol state

	reg [`TW_ST_W-1:0] state_q;
	reg [`TW_PH_W-1:0] phase_q;
	reg [`TW_CNT_W-1:0] cnt_q;
	reg [`TW_BYTE_W-1:0] rx_q;
	reg [`TW_BYTE_W-1:0] tx_q;
	reg [`TW_BYTE_W-1:0] hi_q;
	reg [AW-1:0] addr_q;
	reg dir_read_q;
	reg low_byte_q;
	reg acked_q;

	wire [DW-1:0] rd_data;
	wire [AW-1:0] addr_next = addr_q + {{(AW-1){1'b0}}, 1'b1};
	wire [`TW_BYTE_W-1:0] rd_hi = rd_data[DW-1:DW-`TW_BYTE_W];
	wire [`TW_BYTE_W-1:0] rd_lo = rd_data[`TW_BYTE_W-1:0];
	wire id_match = (rx_q[`TW_BYTE_W-1:1] == DEV_ID);
	wire id_read = (rx_q[0] == `TW_DIR_READ);
	wire byte_done = (cnt_q == `TW_CNT_FULL);

	////////////////////////////////////////////////////////////////////////
	// register storage; every entry can be read back

	reg_store #(
		.AW(AW),
		.DW(DW)
	) u_store (
		.system_clock(system_clock),
		.rst_b(rst_b),
		.wr_en(wr_strobe_q),
		.wr_addr(wr_addr_q),
		.wr_data(wr_data_q),
		.rd_addr(addr_q),
		.rd_data_q(rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// main sequencer

	always @(posedge system_clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= `TW_ST_IDLE;
			phase_q <= `TW_PH_ID;
			cnt_q <= `TW_CNT_ZERO;
			rx_q <= `TW_BYTE_RESET;
			tx_q <= `TW_BYTE_RESET;
			hi_q <= `TW_BYTE_RESET;
			addr_q <= `TW_ADDR_RESET;
			dir_read_q <= 1'b0;
			low_byte_q <= 1'b0;
			acked_q <= 1'b0;
			sda_out_q <= `TW_LINE_LOW;
			sda_oe_b_q <= `TW_RELEASE;
			wr_strobe_q <= 1'b0;
			wr_addr_q <= `TW_ADDR_RESET;
			wr_data_q <= `TW_REG_RESET;
			selected_q <= 1'b0;
		end
		else
		begin
			// only ever pull low; a one is a released line
			sda_out_q <= `TW_LINE_LOW;
			wr_strobe_q <= 1'b0;
			if (start_det)
			begin
				// a start mid-transfer is a repeated start: new identifier
				state_q <= `TW_ST_RECV;
				phase_q <= `TW_PH_ID;
				cnt_q <= `TW_CNT_ZERO;
				sda_oe_b_q <= `TW_RELEASE;
				selected_q <= 1'b0;
			end
			else if (stop_det)
			begin
				// also covers a stop out of sequence
				state_q <= `TW_ST_IDLE;
				sda_oe_b_q <= `TW_RELEASE;
				selected_q <= 1'b0;
			end
			else
			begin
				case (state_q)
				`TW_ST_IDLE:
				begin
					sda_oe_b_q <= `TW_RELEASE;
				end
				`TW_ST_RECV:
				begin
					if (scl_rise && !byte_done)
					begin
						rx_q <= {rx_q[`TW_BYTE_W-2:0], sda_s};
						cnt_q <= cnt_q + `TW_CNT_STEP;
					end
					else if (scl_fall && byte_done)
					begin
						cnt_q <= `TW_CNT_ZERO;
						if (sequencer_busy_flag)
						begin
							// refuse rather than race the sequencer
							state_q <= `TW_ST_IDLE;
							selected_q <= 1'b0;
						end
						else
						begin
							case (phase_q)
							`TW_PH_ID:
							begin
								if (id_match && !(id_read && write_only))
								begin
									dir_read_q <= id_read;
									low_byte_q <= 1'b0;
									selected_q <= 1'b1;
									phase_q <= `TW_PH_ADDR;
									sda_oe_b_q <= `TW_DRIVE;
									state_q <= `TW_ST_RACK;
								end
								else
								begin
									state_q <= `TW_ST_IDLE;
								end
							end
							`TW_PH_ADDR:
							begin
								addr_q <= rx_q;
								phase_q <= `TW_PH_HI;
								sda_oe_b_q <= `TW_DRIVE;
								state_q <= `TW_ST_RACK;
							end
							`TW_PH_HI:
							begin
								hi_q <= rx_q;
								phase_q <= `TW_PH_LO;
								sda_oe_b_q <= `TW_DRIVE;
								state_q <= `TW_ST_RACK;
							end
							default:
							begin
								// second byte completes the word
								wr_strobe_q <= 1'b1;
								wr_addr_q <= addr_q;
								wr_data_q <= {hi_q, rx_q};
								addr_q <= addr_next;
								phase_q <= `TW_PH_HI;
								sda_oe_b_q <= `TW_DRIVE;
								state_q <= `TW_ST_RACK;
							end
							endcase
						end
					end
				end
				`TW_ST_RACK:
				begin
					if (scl_fall)
					begin
						if (dir_read_q)
						begin
							// read from the retained address
							tx_q <= rd_hi;
							sda_oe_b_q <= rd_hi[`TW_BYTE_W-1];
							state_q <= `TW_ST_SEND;
						end
						else
						begin
							sda_oe_b_q <= `TW_RELEASE;
							state_q <= `TW_ST_RECV;
						end
					end
				end
				`TW_ST_SEND:
				begin
					if (scl_rise)
					begin
						cnt_q <= cnt_q + `TW_CNT_STEP;
					end
					else if (scl_fall)
					begin
						if (byte_done)
						begin
							cnt_q <= `TW_CNT_ZERO;
							sda_oe_b_q <= `TW_RELEASE;
							state_q <= `TW_ST_SACK;
						end
						else
						begin
							tx_q <= {tx_q[`TW_BYTE_W-2:0], 1'b0};
							sda_oe_b_q <= tx_q[`TW_BYTE_W-2];
						end
					end
				end
				`TW_ST_SACK:
				begin
					if (scl_rise)
					begin
						acked_q <= (sda_s == `TW_LINE_LOW);
						if (low_byte_q)
							addr_q <= addr_next;
					end
					else if (scl_fall)
					begin
						if (!acked_q || sequencer_busy_flag)
						begin
							// nack ends the read; wait for stop or start
							state_q <= `TW_ST_IDLE;
							selected_q <= 1'b0;
						end
						else
						begin
							// read data settles within the scl high time
							tx_q <= low_byte_q ? rd_hi : rd_lo;
							sda_oe_b_q <= low_byte_q ? rd_hi[`TW_BYTE_W-1] : rd_lo[`TW_BYTE_W-1];
							low_byte_q <= !low_byte_q;
							state_q <= `TW_ST_SEND;
						end
					end
				end
				default:
				begin
					state_q <= `TW_ST_IDLE;
					sda_oe_b_q <= `TW_RELEASE;
				end
				endcase
			end
		end
	end

endmodule // two_wire_register_slave

`default_nettype wire

// ### verification/tw_slave_sva.sv
/* port checker for the two-wire slave
   assumes scl far slower than system_clock */
`timescale 1ns/1ps
`default_nettype none
module tw_slave_sva #(
	parameter AW = 8,
	parameter DW = 16
) (
	// clock and reset
	input wire logic system_clock,
	input wire logic rst_b,
	// pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out_q,
	input wire logic sda_oe_b_q,
	// controls
	input wire logic sequencer_busy_flag,
	input wire logic write_only,
	// results
	input wire logic wr_strobe_q,
	input wire logic [AW-1:0] wr_addr_q,
	input wire logic [DW-1:0] wr_data_q,
	input wire logic selected_q
);
	logic [4:0] busy_n_q;
	logic [AW-1:0] last_q;
	logic have_q;
	// busy count saturates, long enough to cover a byte end
	always @(posedge system_clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_n_q <= 5'h00;
			have_q <= 1'b0;
			last_q <= '0;
		end
		else
		begin
			busy_n_q <= !sequencer_busy_flag ? 5'h00 : (busy_n_q == 5'h14 ? 5'h14 : busy_n_q + 5'h01);
			have_q <= selected_q && (have_q || wr_strobe_q);
			if (wr_strobe_q)
				last_q <= wr_addr_q;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge system_clock); endclocking
	default disable iff (!rst_b);
	sequence stop_seen;
		scl_in && $rose(sda_in);
	endsequence
	sequence drive_start;
		$fell(sda_oe_b_q);
	endsequence
	a_out_low: assert property (sda_out_q == 1'b0)
		else $error("sda driven high");
	a_strobe_pulse: assert property (wr_strobe_q |=> !wr_strobe_q)
		else $error("strobe too long");
	a_strobe_sel: assert property (wr_strobe_q |-> selected_q)
		else $error("write while unselected");
	a_busy_blocks: assert property (busy_n_q == 5'h14 |-> !wr_strobe_q)
		else $error("write while busy");
	a_stop_idle: assert property (stop_seen |-> ##[1:8] !selected_q)
		else $error("stop ignored");
	a_drive_holds: assert property (drive_start |-> !sda_oe_b_q [*6])
		else $error("low drive too short");
	a_addr_step: assert property (wr_strobe_q && have_q |-> wr_addr_q == last_q + 1'b1)
		else $error("address not stepped");
	a_data_hold: assert property (!wr_strobe_q |-> $stable(wr_data_q) && $stable(wr_addr_q))
		else $error("write data moved");
endmodule // tw_slave_sva
bind two_wire_register_slave tw_slave_sva #(.AW(AW), .DW(DW)) u_sva (.system_clock, .rst_b, .scl_in, .sda_in,
	.sda_out_q, .sda_oe_b_q, .sequencer_busy_flag, .write_only, .wr_strobe_q, .wr_addr_q, .wr_data_q, .selected_q);
`default_nettype wire

// ### verification/tw_master.sv
/* bus master model: start, stop, bytes
   assumes sda has a pull-up; moves on system_clock falls */
`timescale 1ns/1ps
`default_nettype none
module tw_master (
	// clock
	input wire logic system_clock,
	// bus
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge system_clock);
	endtask
	// 8 clk per bit: 160 ns
	task automatic bit_x(input logic b, output logic r);
		sda_m = b;
		tick(2);
		scl = 1'b1;
		tick(3);
		r = sda;
		tick(1);
		scl = 1'b0;
		tick(2);
	endtask
	// waits out the slave's ack before releasing
	task automatic start();
		tick(4);
		sda_m = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_m = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b1;
		tick(4);
	endtask
	task automatic wbyte(input logic [7:0] v, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(v[i], r);
		bit_x(1'b1, a);
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, v[i]);
		bit_x(nack, r);
	endtask
endmodule // tw_master
`default_nettype wire

// ### verification/two_wire_register_slave_tb.sv
/* bench: writes, reads, refusals, aborts
   assumes tw_master drives the bus */
`timescale 1ns/1ps
`default_nettype none
module two_wire_register_slave_tb;
	logic system_clock = 1'b0;
	logic rst_b = 1'b0;
	logic busy = 1'b0;
	logic wo = 1'b0;
	logic scl;
	logic sda_m;
	wire logic oe_b;
	wire logic out;
	wire logic sda = sda_m & (oe_b | out);
	wire logic strb;
	wire logic [7:0] waddr;
	wire logic [15:0] wdata;
	wire logic sel;
	logic [23:0] exp_q[$];
	int miscompares = 0;
	int checks = 0;
	always #10 system_clock = ~system_clock;
	tw_master m (.system_clock(system_clock), .scl(scl), .sda_m(sda_m), .sda(sda));
	two_wire_register_slave DUT (.system_clock(system_clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out_q(out), .sda_oe_b_q(oe_b), .sequencer_busy_flag(busy), .write_only(wo),
		.wr_strobe_q(strb), .wr_addr_q(waddr), .wr_data_q(wdata), .selected_q(sel));
	////////////////////////////////////////
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr_byte(input logic [7:0] v, input logic ea);
		logic k;
		m.wbyte(v, k);
		check(24'(k), 24'(ea));
	endtask
	task automatic rd_word(input logic [15:0] e, input logic last);
		logic [7:0] hb;
		logic [7:0] lb;
		m.rbyte(1'b0, hb);
		m.rbyte(last, lb);
		check({8'h00, hb, lb}, {8'h00, e});
	endtask
	// an unexpected write meets an unknown note and fails
	always @(negedge system_clock)
		if (strb === 1'b1)
			check({waddr, wdata}, exp_q.size() ? exp_q.pop_front() : 24'hXXXXXX);
	initial
	begin
		repeat (20000) @(posedge system_clock);
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		logic [7:0] a;
		logic [15:0] d [3];
		logic [7:0] ids [3];
		logic r;
		ids = '{8'h58, 8'h57, 8'h56};
		void'($urandom(32'h752bbbbe));
		a = 8'($urandom_range(253));
		foreach (d[i])
			d[i] = 16'($urandom);
		repeat (5) @(posedge system_clock);
		@(negedge system_clock);
		rst_b = 1'b1;
		m.tick(4);
		m.start();
		wr_byte(8'h56, 1'b0);
		check(24'(sel), 24'h1);
		wr_byte(a, 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			exp_q.push_back({a + 8'(i), d[i]});
			wr_byte(d[i][15:8], 1'b0);
			wr_byte(d[i][7:0], 1'b0);
		end
		m.stop();
		$display("write burst done");
		m.start();
		wr_byte(8'h56, 1'b0);
		wr_byte(a, 1'b0);
		m.start();
		wr_byte(8'h57, 1'b0);
		rd_word(d[0], 1'b0);
		rd_word(d[1], 1'b1);
		m.stop();
		m.start();
		wr_byte(8'h57, 1'b0);
		rd_word(d[2], 1'b1);
		m.stop();
		$display("read burst done");
		// bad id, read while write-only, busy
		for (int i = 0; i < 3; i++)
		begin
			wo = (i == 1);
			busy = (i == 2);
			m.start();
			wr_byte(ids[i], 1'b1);
			check(24'(sel), 24'h0);
			m.stop();
		end
		wo = 1'b0;
		busy = 1'b0;
		$display("refusals done");
		m.start();
		wr_byte(8'h56, 1'b0);
		wr_byte(a, 1'b0);
		wr_byte(8'hA5, 1'b0);
		m.stop();
		// busy raised between the two bytes of a word: low byte refused
		m.start();
		wr_byte(8'h56, 1'b0);
		wr_byte(a, 1'b0);
		wr_byte(8'hA5, 1'b0);
		busy = 1'b1;
		wr_byte(8'h5A, 1'b1);
		busy = 1'b0;
		m.stop();
		m.start();
		wr_byte(8'h56, 1'b0);
		for (int i = 0; i < 3; i++)
			m.bit_x(1'b0, r);
		m.stop();
		m.tick(20);
		check(24'(exp_q.size()), 24'h0);
		$display("aborts done");
		report_and_stop();
	end
endmodule // two_wire_register_slave_tb
`default_nettype wire
